// ==== rtl/vlc_classifier.v ====
// Overview of operation
// - Uplink prefix indexes remote map for VLAN
// - VLAN identifier is two bits wide
// - Lookup key is MAC plus VLAN
// - Entries keep own flags, port, age
// - Local ports 01-14 carry own VLAN
// - Flood mask for unknown, limits multicast
// - Decode prefix into remote source port
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "vlc_classifier_regs.vh"

module vlc_classifier #(
    parameter IDX_W = 2,
    parameter [15:0] AGE_TICK_CYCLES = 16'd1000
) (
    input wire mclk_in, // Core clock, 100 MHz.
    input wire rst_n_in, // Asynchronous reset, active low.
    input wire psel_in, // APB select.
    input wire penable_in, // APB enable.
    input wire pwrite_in, // APB write direction.
    input wire [7:0] paddr_in, // APB byte address.
    input wire [31:0] pwdata_in, // APB write data.
    output wire pready_out, // APB ready, always high.
    output reg [31:0] prdata_out, // APB read data.
    output wire pslverr_out, // APB error on unmapped address.
    input wire frame_valid_in, // One-cycle strobe: a snooped frame header.
    input wire [3:0] src_port_in, // Port the frame was sourced on.
    input wire [3:0] prefix_in, // Source-port prefix of uplink frames.
    input wire [47:0] sa_in, // Source MAC address.
    input wire [47:0] da_in, // Destination MAC address.
    output reg result_valid_out, // One-cycle strobe: result below is new.
    output reg [1:0] vlan_out, // VLAN given to the frame.
    output reg [3:0] remote_port_out, // Remote source port, uplink only.
    output reg found_out, // Destination key was in the table.
    output reg [14:0] dest_ports_out // Ports the frame is routed to.
);

    localparam NUM_ENTRIES = 1 << IDX_W;
    localparam VW = `VLC_VLAN_W;
    localparam NP = `VLC_NUM_PORTS;

    // ************************************************************
    // Helpers.
    // ************************************************************

    // Picks a two-bit VLAN field from a packed word of 16 fields.
    function [1:0] vlc_field;
        input [31:0] word;
        input [3:0] idx;
        begin
            vlc_field = word[{idx, 1'b0} +: 2];
        end
    endfunction

    // ************************************************************
    // Registers.
    // ************************************************************
    reg [31:0] port_vlan_assignment_r;
    reg [31:0] remote_port_vlan_map_r;
    reg [NP-1:0] per_vlan_flood_mask_r [0:3];
    reg [7:0] age_limit_r;
    reg [15:0] tick_cnt_r;
    reg ent_valid_r [0:NUM_ENTRIES-1];
    reg [47:0] ent_mac_r [0:NUM_ENTRIES-1];
    reg [VW-1:0] ent_vlan_r [0:NUM_ENTRIES-1];
    reg [3:0] ent_port_r [0:NUM_ENTRIES-1];
    reg [7:0] ent_age_r [0:NUM_ENTRIES-1];

    wire setup = psel_in & ~penable_in;
    wire wr_en = psel_in & penable_in & pwrite_in;
    reg mapped;

    // Zero wait states: read data is caught in the setup cycle.
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in & penable_in & ~mapped;

    // ************************************************************
    // Classification and table search.
    // ************************************************************
    reg [1:0] vlan_sel;
    reg sa_hit;
    reg da_hit;
    reg free_found;
    reg [IDX_W-1:0] sa_idx;
    reg [IDX_W-1:0] da_idx;
    reg [IDX_W-1:0] free_idx;
    reg [14:0] dest_sel;
    reg [7:0] count;
    integer i;
    integer j;

    // Uplink frames take the remote map, local frames their own port field.
    always @* begin
        if (src_port_in == `VLC_UPLINK_PORT) begin
            vlan_sel = vlc_field(remote_port_vlan_map_r, prefix_in);
        end else begin
            vlan_sel = vlc_field(port_vlan_assignment_r, src_port_in);
        end
    end

    // Search every entry by MAC and VLAN together, so duplicates coexist.
    always @* begin
        sa_hit = 1'b0;
        da_hit = 1'b0;
        free_found = 1'b0;
        sa_idx = {IDX_W{1'b0}};
        da_idx = {IDX_W{1'b0}};
        free_idx = {IDX_W{1'b0}};
        count = 8'h00;
        for (i = 0; i < NUM_ENTRIES; i = i + 1) begin
            if (ent_valid_r[i]) begin
                count = count + 8'h01;
                if (ent_mac_r[i] == sa_in && ent_vlan_r[i] == vlan_sel) begin
                    sa_hit = 1'b1;
                    sa_idx = i[IDX_W-1:0];
                end
                if (ent_mac_r[i] == da_in && ent_vlan_r[i] == vlan_sel) begin
                    da_hit = 1'b1;
                    da_idx = i[IDX_W-1:0];
                end
            end else if (!free_found) begin
                free_found = 1'b1;
                free_idx = i[IDX_W-1:0];
            end
        end
    end

    // Unknown goes to the VLAN flood set; known multicast is trimmed by it.
    always @* begin
        if (!da_hit) begin
            dest_sel = per_vlan_flood_mask_r[vlan_sel];
        end else begin
            dest_sel = 15'h0001 << ent_port_r[da_idx];
            if (da_in[`VLC_MCAST_BIT]) begin
                dest_sel = dest_sel & per_vlan_flood_mask_r[vlan_sel];
            end
        end
        // A frame is never sent back out the port it came in on.
        dest_sel = dest_sel & ~(15'h0001 << src_port_in);
    end

    // Result register: one cycle after the frame strobe.
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            result_valid_out <= 1'b0;
            vlan_out <= 2'h0;
            remote_port_out <= 4'h0;
            found_out <= 1'b0;
            dest_ports_out <= 15'h0000;
        end else begin
            result_valid_out <= frame_valid_in;
            if (frame_valid_in) begin
                vlan_out <= vlan_sel;
                remote_port_out <= (src_port_in == `VLC_UPLINK_PORT) ? prefix_in : 4'h0;
                found_out <= da_hit;
                dest_ports_out <= dest_sel;
            end
        end
    end

    // ************************************************************
    // Learning and expiry.
    // ************************************************************

    // Free-running tick that paces the entry_expiry_logic.
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tick_cnt_r <= 16'h0000;
        end else if (tick_cnt_r == AGE_TICK_CYCLES - 16'd1) begin
            tick_cnt_r <= 16'h0000;
        end else begin
            tick_cnt_r <= tick_cnt_r + 16'd1;
        end
    end

    wire age_tick = (tick_cnt_r == AGE_TICK_CYCLES - 16'd1);
    wire learn = frame_valid_in & ~sa_in[`VLC_MCAST_BIT] & (sa_hit | free_found);
    wire [IDX_W-1:0] learn_idx = sa_hit ? sa_idx : free_idx;

    // Each entry keeps its own valid flag, port and age; a full table drops new sources.
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (j = 0; j < NUM_ENTRIES; j = j + 1) begin
                ent_valid_r[j] <= 1'b0;
                ent_mac_r[j] <= 48'h000000000000;
                ent_vlan_r[j] <= 2'h0;
                ent_port_r[j] <= 4'h0;
                ent_age_r[j] <= 8'h00;
            end
        end else begin
            for (j = 0; j < NUM_ENTRIES; j = j + 1) begin
                if (learn && learn_idx == j[IDX_W-1:0]) begin
                    ent_valid_r[j] <= 1'b1;
                    ent_mac_r[j] <= sa_in;
                    ent_vlan_r[j] <= vlan_sel;
                    ent_port_r[j] <= src_port_in;
                    ent_age_r[j] <= 8'h00;
                end else if (age_tick && ent_valid_r[j]) begin
                    if (ent_age_r[j] >= age_limit_r) begin
                        ent_valid_r[j] <= 1'b0;
                    end else begin
                        ent_age_r[j] <= ent_age_r[j] + 8'h01;
                    end
                end
            end
        end
    end

    // ************************************************************
    // APB register file.
    // ************************************************************

    // Address decode for the error answer only; read data has its own case on the address.
    always @* begin
        case (paddr_in)
            `VLC_ADDR_PORT_VLAN, `VLC_ADDR_REMOTE_MAP, `VLC_ADDR_FLOOD0,
            `VLC_ADDR_FLOOD1, `VLC_ADDR_FLOOD2, `VLC_ADDR_FLOOD3,
            `VLC_ADDR_AGE_LIMIT, `VLC_ADDR_STATUS: begin
                mapped = 1'b1;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // Writes land at the access edge; port 00 and port 15 fields stay zero.
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            port_vlan_assignment_r <= 32'h00000000;
            remote_port_vlan_map_r <= 32'h00000000;
            per_vlan_flood_mask_r[0] <= `VLC_FLOOD_RESET;
            per_vlan_flood_mask_r[1] <= `VLC_FLOOD_RESET;
            per_vlan_flood_mask_r[2] <= `VLC_FLOOD_RESET;
            per_vlan_flood_mask_r[3] <= `VLC_FLOOD_RESET;
            age_limit_r <= `VLC_AGE_LIMIT_RESET;
        end else if (wr_en) begin
            case (paddr_in)
                `VLC_ADDR_PORT_VLAN: begin
                    port_vlan_assignment_r <= {2'h0, pwdata_in[29:2], 2'h0};
                end
                `VLC_ADDR_REMOTE_MAP: begin
                    remote_port_vlan_map_r <= pwdata_in;
                end
                `VLC_ADDR_FLOOD0: begin
                    per_vlan_flood_mask_r[0] <= pwdata_in[NP-1:0];
                end
                `VLC_ADDR_FLOOD1: begin
                    per_vlan_flood_mask_r[1] <= pwdata_in[NP-1:0];
                end
                `VLC_ADDR_FLOOD2: begin
                    per_vlan_flood_mask_r[2] <= pwdata_in[NP-1:0];
                end
                `VLC_ADDR_FLOOD3: begin
                    per_vlan_flood_mask_r[3] <= pwdata_in[NP-1:0];
                end
                `VLC_ADDR_AGE_LIMIT: begin
                    age_limit_r <= pwdata_in[7:0];
                end
                default: begin
                    age_limit_r <= age_limit_r;
                end
            endcase
        end
    end

    // Read data is sampled at the setup edge and held through the access cycle.
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prdata_out <= 32'h00000000;
        end else if (setup) begin
            case (paddr_in)
                `VLC_ADDR_PORT_VLAN: prdata_out <= port_vlan_assignment_r;
                `VLC_ADDR_REMOTE_MAP: prdata_out <= remote_port_vlan_map_r;
                `VLC_ADDR_FLOOD0: prdata_out <= {17'h0, per_vlan_flood_mask_r[0]};
                `VLC_ADDR_FLOOD1: prdata_out <= {17'h0, per_vlan_flood_mask_r[1]};
                `VLC_ADDR_FLOOD2: prdata_out <= {17'h0, per_vlan_flood_mask_r[2]};
                `VLC_ADDR_FLOOD3: prdata_out <= {17'h0, per_vlan_flood_mask_r[3]};
                `VLC_ADDR_AGE_LIMIT: prdata_out <= {24'h000000, age_limit_r};
                `VLC_ADDR_STATUS: begin
                    prdata_out <= {16'h0000, count, remote_port_out, 1'b0, vlan_out, found_out};
                end
                default: prdata_out <= 32'h00000000;
            endcase
        end
    end

endmodule

`default_nettype wire

// ==== rtl/vlc_classifier_regs.vh ====
`ifndef VLC_CLASSIFIER_REGS_VH
`define VLC_CLASSIFIER_REGS_VH

// ************************************************************
// Register byte addresses on the APB bus.
// ************************************************************
`define VLC_ADDR_PORT_VLAN   8'h00
`define VLC_ADDR_REMOTE_MAP  8'h04
`define VLC_ADDR_FLOOD0      8'h08
`define VLC_ADDR_FLOOD1      8'h0C
`define VLC_ADDR_FLOOD2      8'h10
`define VLC_ADDR_FLOOD3      8'h14
`define VLC_ADDR_AGE_LIMIT   8'h18
`define VLC_ADDR_STATUS      8'h1C

// ************************************************************
// Field sizes, positions and reset values.
// ************************************************************
`define VLC_VLAN_W           2
`define VLC_PORT_W           4
`define VLC_NUM_PORTS        15
`define VLC_UPLINK_PORT      4'h0
`define VLC_MAC_W            48
`define VLC_MCAST_BIT        40
`define VLC_FLOOD_RESET      15'h7FFF
`define VLC_AGE_LIMIT_W      8
`define VLC_AGE_LIMIT_RESET  8'hFF
`define VLC_STAT_FOUND_BIT   0
`define VLC_STAT_VLAN_LSB    1
`define VLC_STAT_RPORT_LSB   4
`define VLC_STAT_COUNT_LSB   8

`endif

// ==== bench/vlc_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
// ********
// Port checker.
// ********
module vlc_monitor (
    input wire logic mclk_in, // Clock.
    input wire logic rst_n_in, // Reset.
    input wire logic psel_in, // Select.
    input wire logic penable_in, // Enable.
    input wire logic pready_out, // Ready.
    input wire logic pslverr_out, // Error.
    input wire logic frame_valid_in, // Header.
    input wire logic [3:0] src_port_in, // Source.
    input wire logic [3:0] prefix_in, // Prefix.
    input wire logic result_valid_out, // Result.
    input wire logic [1:0] vlan_out, // VLAN.
    input wire logic [3:0] remote_port_out, // Remote.
    input wire logic [14:0] dest_ports_out // Ports.
);
    // One clock domain, so clock and reset are given once.
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    a_result_one_later: assert property (frame_valid_in |=> result_valid_out)
        else $error("No result after a header.");
    a_result_has_cause: assert property (result_valid_out |-> $past(frame_valid_in))
        else $error("Result without a header.");
    a_uplink_prefix: assert property (frame_valid_in && src_port_in == 4'h0
        |=> remote_port_out == $past(prefix_in)) else $error("Remote port wrong.");
    a_local_no_remote: assert property (frame_valid_in && src_port_in != 4'h0
        |=> remote_port_out == 4'h0) else $error("Remote port on local frame.");
    a_source_excluded: assert property (frame_valid_in && src_port_in != 4'hF
        |=> dest_ports_out[$past(src_port_in)] == 1'b0) else $error("Sent back to source.");
    a_fields_hold: assert property (!frame_valid_in
        |=> $stable(vlan_out) && $stable(dest_ports_out) && $stable(remote_port_out))
        else $error("Result moved without a header.");
    a_error_in_access: assert property (pslverr_out |-> psel_in && penable_in)
        else $error("Error outside access phase.");
    a_ready_in_access: assert property (psel_in && penable_in |-> pready_out)
        else $error("Access phase stalled.");
endmodule
bind vlc_classifier vlc_monitor u_mon (.mclk_in, .rst_n_in, .psel_in, .penable_in, .pready_out,
    .pslverr_out, .frame_valid_in, .src_port_in, .prefix_in, .result_valid_out, .vlan_out,
    .remote_port_out, .dest_ports_out);
`default_nettype wire

// ==== bench/vlc_frame_source.sv ====
`timescale 1ns/1ns
`default_nettype none
// ********
// Snooped header source.
// ********
module vlc_frame_source (
    input wire logic mclk_in, // Clock.
    output var logic frame_valid_out, // Strobe.
    output var logic [3:0] src_port_out, // Source.
    output var logic [3:0] prefix_out, // Prefix.
    output var logic [47:0] sa_out, // Source MAC.
    output var logic [47:0] da_out // Dest MAC.
);
    // Quiet bus at time zero.
    initial begin
        frame_valid_out = 1'b0;
        src_port_out = 4'hF;
        prefix_out = 4'h0;
        sa_out = 48'h0;
        da_out = 48'h0;
    end
    // Fields flip after the strobe, so a stale header is never read as held.
    task automatic send(input logic [3:0] s, input logic [3:0] p, input logic [47:0] a,
        input logic [47:0] b);
        @(posedge mclk_in);
        frame_valid_out <= 1'b1;
        src_port_out <= s;
        prefix_out <= p;
        sa_out <= a;
        da_out <= b;
        @(posedge mclk_in);
        frame_valid_out <= 1'b0;
        src_port_out <= ~s;
        prefix_out <= ~p;
        sa_out <= ~a;
        da_out <= ~b;
    endtask
endmodule
`default_nettype wire

// ==== bench/test_vlc_classifier.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "vlc_classifier_regs.vh"
// ********
// Self-checking bench.
// ********
module test_vlc_classifier;
    localparam logic [47:0] mc_sa = 48'h0100_0000_0000;
    localparam logic [47:0] unk_da = 48'h0000_0000_0AAA;
    localparam logic [47:0] dup_mac = 48'h1234_5678_9ABC;
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic pready, pslverr, err, fv, rv, found;
    logic [31:0] prdata, rd;
    logic [3:0] src, pfx, rport;
    logic [47:0] sa, da;
    logic [1:0] vlan;
    logic [14:0] dest;
    logic [14:0] mask [4];
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;
    // Clock at 100 MHz.
    always #5 mclk_in = ~mclk_in;
    vlc_classifier dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr), .frame_valid_in(fv),
        .src_port_in(src), .prefix_in(pfx), .sa_in(sa), .da_in(da), .result_valid_out(rv),
        .vlan_out(vlan), .remote_port_out(rport), .found_out(found), .dest_ports_out(dest));
    vlc_frame_source u_src (.mclk_in(mclk_in), .frame_valid_out(fv), .src_port_out(src),
        .prefix_out(pfx), .sa_out(sa), .da_out(da));
    // A hang ends the run through the same report.
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 4000) begin
            n_mismatch++;
            close_out();
        end
    end
    task close_out();
        $display("counts: run %0d, mismatch %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // APB transfer, held until pready is seen high at an edge.
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_in);
        penable <= 1'b1;
        @(posedge mclk_in);
        while (pready !== 1'b1)
            @(posedge mclk_in);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // One header in; the result is judged on its strobe cycle.
    task frame(input logic [3:0] s, input logic [3:0] p, input logic [47:0] a,
        input logic [47:0] b, input logic [1:0] ev, input logic ef, input logic [14:0] ed);
        u_src.send(s, p, a, b);
        #1;
        chk({31'h0, rv}, 32'h1);
        chk({30'h0, vlan}, {30'h0, ev});
        chk({31'h0, found}, {31'h0, ef});
        chk({17'h0, dest}, {17'h0, ed});
        chk({28'h0, rport}, (s == 4'h0) ? {28'h0, p} : 32'h0);
    endtask
    task t_reset();
        apb(1'b0, `VLC_ADDR_FLOOD3, 32'h0);
        chk(rd, 32'h0000_7FFF);
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        $display("test reset done");
    endtask
    task t_local();
        logic [31:0] pv;
        pv = 32'h0;
        for (int v = 0; v < 4; v++)
            mask[v] = 15'h0001;
        for (int p = 1; p < 15; p++) begin
            pv[2*p +: 2] = 2'(p % 4);
            mask[p % 4][p] = 1'b1;
        end
        apb(1'b1, `VLC_ADDR_PORT_VLAN, pv);
        for (int v = 0; v < 4; v++)
            apb(1'b1, `VLC_ADDR_FLOOD0 + 8'(4 * v), {17'h0, mask[v]});
        // Prefix 3 with an empty map would give VLAN 0 if misused.
        for (int p = 1; p < 15; p++)
            frame(4'(p), 4'h3, mc_sa, unk_da, 2'(p % 4), 1'b0, mask[p % 4] & ~(15'h1 << p));
        $display("test local done");
    endtask
    task t_uplink();
        apb(1'b1, `VLC_ADDR_REMOTE_MAP, 32'h0000_001B);
        frame(4'h0, 4'h1, mc_sa, unk_da, 2'h2, 1'b0, mask[2] & 15'h7FFE);
        apb(1'b1, `VLC_ADDR_REMOTE_MAP, 32'h0000_00E4);
        for (int i = 0; i < 4; i++)
            frame(4'h0, 4'(i), mc_sa, unk_da, 2'(i), 1'b0, mask[i] & 15'h7FFE);
        frame(4'h0, 4'h5, mc_sa, unk_da, 2'h0, 1'b0, mask[0] & 15'h7FFE);
        $display("test uplink done");
    endtask
    task t_dup();
        frame(4'h2, 4'h0, dup_mac, unk_da, 2'h2, 1'b0, mask[2] & ~15'h0004);
        frame(4'h5, 4'h0, dup_mac, unk_da, 2'h1, 1'b0, mask[1] & ~15'h0020);
        frame(4'h6, 4'h0, mc_sa, dup_mac, 2'h2, 1'b1, 15'h0004);
        frame(4'h9, 4'h0, mc_sa, dup_mac, 2'h1, 1'b1, 15'h0020);
        apb(1'b0, `VLC_ADDR_STATUS, 32'h0);
        chk({24'h0, rd[15:8]}, 32'h2);
        $display("test duplicate done");
    endtask
    // Limit 0 expires every entry at the next tick; a tick comes every 1000 cycles.
    task t_age();
        apb(1'b1, `VLC_ADDR_AGE_LIMIT, 32'h0);
        apb(1'b0, `VLC_ADDR_AGE_LIMIT, 32'h0);
        chk(rd, 32'h0);
        repeat (1005) @(posedge mclk_in);
        apb(1'b0, `VLC_ADDR_STATUS, 32'h0);
        chk({24'h0, rd[15:8]}, 32'h0);
        frame(4'h6, 4'h0, mc_sa, dup_mac, 2'h2, 1'b0, mask[2] & ~15'h0040);
        $display("test expiry done");
    endtask
    // Reset for three cycles, then the scenarios in turn.
    initial begin
        repeat (3) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        t_reset();
        t_local();
        t_uplink();
        t_dup();
        t_age();
        close_out();
    end
endmodule
`default_nettype wire
